// >>> hdl/tcl_lamp_regs.vh
// Behaviour
// - All five lamps lit eleven seconds after power
// - Self-test start: five lamps dark one second
// - Full pass: five lamps blink three times
// - Partial failure: five lamps blink five times
// - After indication lamps follow card state
// - Out-of-service lamp lit while card disabled
// - In-service lamp: no alarm, enabled, no loopback
// - Local-alarm lamp follows red alarm
// - Far-end-alarm lamp follows yellow alarm
// - Loop-test lamp lit during loopback
// - Clock-controller lamp dark two seconds first
// - Clock-controller pass: red, blinks twice
// - Clock lamp red until enabled, then green
// - Handler lamp steady red at power-up, no test
// - Handler enabled: lamp steady green
// - Local test loops internally, checks four functions
// - Local test for whole loop or one channel
`ifndef TCL_LAMP_REGS_VH
`define TCL_LAMP_REGS_VH
`define TCL_CLK_HZ         100000000
`define TCL_HALF_SEC_MS    500
`define TCL_HALF_SEC_CYC   ((`TCL_CLK_HZ / 1000) * `TCL_HALF_SEC_MS)
`define TCL_LAMP_ON_HALVES 8'h16
`define TCL_DARK_HALVES    8'h02
`define TCL_PASS_BLINKS    8'h03
`define TCL_PART_BLINKS    8'h05
`define TCL_CC_DARK_HALVES 8'h04
`define TCL_CC_BLINKS      8'h02
`define TCL_ADDR_CTRL      4'h0
`define TCL_ADDR_STAT      4'h4
`define TCL_ADDR_LAMP      4'h8
`define TCL_CTRL_RESET     8'h00
`endif

// >>> hdl/tcl_tick_gen.v
`timescale 1ns/1ns
`include "tcl_lamp_regs.vh"
module tcl_tick_gen #(
  parameter HALF_CYC = `TCL_HALF_SEC_CYC
) (
  // Clock and reset
  input  wire ref_clk,
  input  wire srst,
  // Half-second tick
  output reg  halfTick
);
  reg [31:0] cnt_r;
  // Tick divider timing every blink and delay
  always @(posedge ref_clk) begin
    if (srst) begin
      cnt_r    <= 32'h0;
      halfTick <= 1'b0;
    end else if (cnt_r == HALF_CYC - 1) begin
      cnt_r    <= 32'h0;
      halfTick <= 1'b1;
    end else begin
      cnt_r    <= cnt_r + 32'h1;
      halfTick <= 1'b0;
    end
  end
endmodule

// >>> hdl/tcl_lamp_seq.v
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "tcl_lamp_regs.vh"
module tcl_lamp_seq #(
  parameter HALF_CYC = `TCL_HALF_SEC_CYC
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       srst,
  // Card state from detectors (pins)
  input  wire       redAlarmIn,
  input  wire       yellowAlarmIn,
  input  wire       testPassIn,
  input  wire       testPartialIn,
  input  wire       ccTestPassIn,
  // Register port
  input  wire [3:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdata,
  // Local loopback test control
  output reg        loopTestActive,
  output reg        loopTestWhole,
  output reg  [4:0] loopTestChan,
  // Lamps
  output reg        outOfServiceLamp,
  output reg        inServiceLamp,
  output reg        localAlarmLamp,
  output reg        farEndAlarmLamp,
  output reg        loopTestLamp,
  output reg        clockLampRed,
  output reg        clockLampGreen,
  output reg        handlerLampRed,
  output reg        handlerLampGreen
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg  [4:0] syncA_r;
  reg  [4:0] syncB_r;
  wire [4:0] pinIn = {ccTestPassIn, testPartialIn, testPassIn, yellowAlarmIn, redAlarmIn};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gSync
      always @(posedge ref_clk) begin
        if (srst) begin
          syncA_r[gi] <= 1'b0;
          syncB_r[gi] <= 1'b0;
        end else begin
          syncA_r[gi] <= pinIn[gi];
          syncB_r[gi] <= syncA_r[gi];
        end
      end
    end
  endgenerate
  wire redAlarm    = syncB_r[0];
  wire yellowAlarm = syncB_r[1];
  wire testPass    = syncB_r[2];
  wire testPartial = syncB_r[3];
  wire ccPass      = syncB_r[4];

  wire halfTick;
  tcl_tick_gen #(
    .HALF_CYC (HALF_CYC)
  ) uTick (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .halfTick (halfTick)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Bits: 0 card disabled, 1 loopback, 2 clock ctrl enabled,
  // 3 clock green flashing, 4 handler enabled, 5 test start,
  // 6 test whole loop, 7 test stop
  reg  [7:0] ctrl_r;
  reg  [4:0] chanSel_r;
  wire       cardDisabled = ctrl_r[0];
  wire       loopback     = ctrl_r[1];
  wire       ccEnabled    = ctrl_r[2];
  wire       ccFlash      = ctrl_r[3];
  wire       dchEnabled   = ctrl_r[4];
  wire       wrCtrl = regWr && (regAddr == `TCL_ADDR_CTRL);
  wire       wrChan = regWr && (regAddr == `TCL_ADDR_LAMP);
  wire       startReq = wrCtrl && regWdata[5];
  wire       stopReq  = wrCtrl && regWdata[7];
  always @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r    <= `TCL_CTRL_RESET;
      chanSel_r <= 5'h00;
    end else begin
      if (wrCtrl)
        ctrl_r <= {3'h0, regWdata[4:0]};
      if (wrChan)
        chanSel_r <= regWdata[4:0];
    end
  end

  // ----------------------------------------
  // Local loopback test
  // ----------------------------------------
  // Internal loop only; software must have disabled the card, handler or
  // channel first; a whole-loop start with the handler enabled is only flagged in testRefused_r, never blocked.
  reg testRefused_r;
  always @(posedge ref_clk) begin
    if (srst) begin
      loopTestActive <= 1'b0;
      loopTestWhole  <= 1'b0;
      loopTestChan   <= 5'h00;
      testRefused_r  <= 1'b0;
    end else if (stopReq) begin
      loopTestActive <= 1'b0;
    end else if (startReq) begin
      loopTestActive <= 1'b1;
      loopTestWhole  <= regWdata[6];
      loopTestChan   <= chanSel_r;
      // Flag a whole-card test while handler still enabled
      testRefused_r  <= regWdata[6] && dchEnabled;
    end
  end

  // ----------------------------------------
  // Card lamp sequencer
  // ----------------------------------------
  localparam S_POWER = 3'h0;
  localparam S_DARK  = 3'h1;
  localparam S_BLINK = 3'h2;
  localparam S_LIVE  = 3'h3;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [7:0] halves_r;
  reg [7:0] halves_nxt;
  reg [7:0] blinkTarget_r;
  reg [7:0] blinkTarget_nxt;
  reg       blinkOn;
  always @* begin
    st_nxt          = st_r;
    halves_nxt      = halves_r;
    blinkTarget_nxt = blinkTarget_r;
    blinkOn         = 1'b0;
    case (st_r)
      S_POWER: begin
        blinkOn = 1'b1;
        if (halfTick) begin
          if (halves_r == `TCL_LAMP_ON_HALVES - 8'h01) begin
            st_nxt     = S_DARK;
            halves_nxt = 8'h00;
          end else begin
            halves_nxt = halves_r + 8'h01;
          end
        end
      end
      S_DARK: begin
        blinkOn = 1'b0;
        if (halfTick) begin
          if (halves_r == `TCL_DARK_HALVES - 8'h01) begin
            st_nxt     = S_BLINK;
            halves_nxt = 8'h00;
            // Results taken once, as the dark second ends
            // Partial failure wins if both results show
            blinkTarget_nxt = testPartial ? (`TCL_PART_BLINKS << 1) :
                              testPass ? (`TCL_PASS_BLINKS << 1) :
                              8'h00;
            if (!testPartial && !testPass)
              st_nxt = S_LIVE;
          end else begin
            halves_nxt = halves_r + 8'h01;
          end
        end
      end
      S_BLINK: begin
        blinkOn = ~halves_r[0];
        if (halfTick) begin
          if (halves_r == blinkTarget_r - 8'h01) begin
            st_nxt     = S_LIVE;
            halves_nxt = 8'h00;
          end else begin
            halves_nxt = halves_r + 8'h01;
          end
        end
      end
      S_LIVE: begin
        blinkOn = 1'b0;
      end
      default: begin
        st_nxt     = S_POWER;
        halves_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      st_r          <= S_POWER;
      halves_r      <= 8'h00;
      blinkTarget_r <= 8'h00;
    end else begin
      st_r          <= st_nxt;
      halves_r      <= halves_nxt;
      blinkTarget_r <= blinkTarget_nxt;
    end
  end

  wire live = (st_r == S_LIVE);
  always @(posedge ref_clk) begin
    if (srst) begin
      outOfServiceLamp <= 1'b1;
      inServiceLamp    <= 1'b1;
      localAlarmLamp   <= 1'b1;
      farEndAlarmLamp  <= 1'b1;
      loopTestLamp     <= 1'b1;
    end else if (live) begin
      outOfServiceLamp <= cardDisabled;
      inServiceLamp    <= !redAlarm && !yellowAlarm && !cardDisabled && !loopback;
      localAlarmLamp   <= redAlarm;
      farEndAlarmLamp  <= yellowAlarm;
      loopTestLamp     <= loopback;
    end else begin
      outOfServiceLamp <= blinkOn;
      inServiceLamp    <= blinkOn;
      localAlarmLamp   <= blinkOn;
      farEndAlarmLamp  <= blinkOn;
      loopTestLamp     <= blinkOn;
    end
  end

  // ----------------------------------------
  // Clock-controller lamp
  // ----------------------------------------
  localparam C_DARK  = 2'h0;
  localparam C_BLINK = 2'h1;
  localparam C_DONE  = 2'h2;
  reg [1:0] cst_r;
  reg [7:0] cHalves_r;
  reg       flashPhase_r;
  // Flash phase runs free, so green flashing stays on the tick grid
  always @(posedge ref_clk) begin
    if (srst) begin
      cst_r        <= C_DARK;
      cHalves_r    <= 8'h00;
      flashPhase_r <= 1'b0;
    end else begin
      if (halfTick)
        flashPhase_r <= ~flashPhase_r;
      case (cst_r)
        C_DARK: if (halfTick) begin
          if (cHalves_r == `TCL_CC_DARK_HALVES - 8'h01) begin
            cHalves_r <= 8'h00;
            cst_r     <= ccPass ? C_BLINK : C_DONE;
          end else begin
            cHalves_r <= cHalves_r + 8'h01;
          end
        end
        C_BLINK: if (halfTick) begin
          if (cHalves_r == (`TCL_CC_BLINKS << 1) - 8'h01) begin
            cHalves_r <= 8'h00;
            cst_r     <= C_DONE;
          end else begin
            cHalves_r <= cHalves_r + 8'h01;
          end
        end
        C_DONE: cst_r <= C_DONE;
        default: cst_r <= C_DARK;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      clockLampRed     <= 1'b0;
      clockLampGreen   <= 1'b0;
      handlerLampRed   <= 1'b1;
      handlerLampGreen <= 1'b0;
    end else begin
      clockLampRed   <= (cst_r == C_BLINK) ? ~cHalves_r[0] :
                        (cst_r == C_DONE) && !ccEnabled;
      clockLampGreen <= (cst_r == C_DONE) && ccEnabled && (!ccFlash || flashPhase_r);
      handlerLampRed   <= !dchEnabled;
      handlerLampGreen <= dchEnabled;
    end
  end

  // ----------------------------------------
  // Read back, one cycle after the strobe
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `TCL_ADDR_CTRL: regRdata <= ctrl_r;
        // Spare bit keeps the clock state a three-bit field
        `TCL_ADDR_STAT: regRdata <= {testRefused_r, loopTestActive, 1'b0, cst_r, st_r};
        `TCL_ADDR_LAMP: regRdata <= {3'h0, chanSel_r};
        default:        regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule

// >>> test/tcl_lamp_seq_assertions.sv
`timescale 1ns/1ns
module tcl_lamp_seq_chk #(
  parameter HALF_CYC = 10
) (
  // Clock, reset, inputs
  input wire       ref_clk,
  input wire       srst,
  input wire       redAlarmIn,
  input wire       yellowAlarmIn,
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire       regWr,
  input wire       loopTestActive,
  // Lamps
  input wire       outOfServiceLamp,
  input wire       inServiceLamp,
  input wire       localAlarmLamp,
  input wire       farEndAlarmLamp,
  input wire       loopTestLamp,
  input wire       clockLampRed,
  input wire       clockLampGreen,
  input wire       handlerLampRed,
  input wire       handlerLampGreen
);
  // ----------------------------------------
  // Power-up timeline
  // ----------------------------------------
  // Saturates past the longest indication so live checks stay armed
  int       upCnt_r;
  wire      live = upCnt_r >= 36 * HALF_CYC;
  wire [4:0] card = {outOfServiceLamp, inServiceLamp, localAlarmLamp, farEndAlarmLamp,
                     loopTestLamp};
  always @(posedge ref_clk) begin
    if (srst)
      upCnt_r <= 0;
    else if (!live)
      upCnt_r <= upCnt_r + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence ctrlWr;
    live && regWr && regAddr == 4'h0;
  endsequence
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_power_lit: assert property (upCnt_r < 21 * HALF_CYC |-> card == 5'h1f)
    else $error("card lamps not lit after power");
  chk_dark_second: assert property (upCnt_r >= 22 * HALF_CYC + 3 &&
    upCnt_r <= 24 * HALF_CYC - 3 |-> card == 5'h00) else $error("card lamps not dark");
  chk_blink_joint: assert property (upCnt_r < 30 * HALF_CYC - 3 |->
    card == 5'h00 || card == 5'h1f) else $error("card lamps not moving together");
  chk_disable_lamp: assert property (ctrlWr |-> ##2
    outOfServiceLamp == $past(regWdata[0], 2)) else $error("out of service lamp wrong");
  chk_in_service: assert property (live && inServiceLamp |-> !(outOfServiceLamp ||
    localAlarmLamp || farEndAlarmLamp || loopTestLamp)) else $error("in service lamp wrong");
  chk_red_alarm: assert property ((live && redAlarmIn) [*5] |-> localAlarmLamp)
    else $error("local alarm lamp dark");
  chk_yellow_clear: assert property ((live && !yellowAlarmIn) [*5] |-> !farEndAlarmLamp)
    else $error("far-end alarm lamp lit");
  chk_loop_lamp: assert property (ctrlWr ##0 !loopTestActive && !regWdata[5] |-> ##2
    loopTestLamp == $past(regWdata[1], 2)) else $error("loop lamp wrong");
  chk_cc_dark: assert property (upCnt_r < 4 * HALF_CYC - 3 |->
    !clockLampRed && !clockLampGreen) else $error("clock lamp lit early");
  chk_cc_enable: assert property (ctrlWr ##0 regWdata[2] && !regWdata[3] |->
    ##[1:3] clockLampGreen && !clockLampRed) else $error("clock lamp not green");
  chk_handler_red: assert property ($fell(srst) |->
    handlerLampRed && !handlerLampGreen) else $error("handler lamp not red");
  chk_handler_green: assert property (ctrlWr ##0 regWdata[4] |-> ##2
    handlerLampGreen && !handlerLampRed) else $error("handler lamp not green");
endmodule
bind tcl_lamp_seq tcl_lamp_seq_chk #(.HALF_CYC(HALF_CYC)) chk (
  .ref_clk(ref_clk), .srst(srst), .redAlarmIn(redAlarmIn), .yellowAlarmIn(yellowAlarmIn),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .loopTestActive(loopTestActive),
  .outOfServiceLamp(outOfServiceLamp), .inServiceLamp(inServiceLamp),
  .localAlarmLamp(localAlarmLamp), .farEndAlarmLamp(farEndAlarmLamp),
  .loopTestLamp(loopTestLamp), .clockLampRed(clockLampRed), .clockLampGreen(clockLampGreen),
  .handlerLampRed(handlerLampRed), .handlerLampGreen(handlerLampGreen));

// >>> test/tcl_lamp_seq_test.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin nFail++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tcl_lamp_seq_test;
  localparam H = 10;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg redAlarmIn = 1'b0, yellowAlarmIn = 1'b0, testPassIn = 1'b0, testPartialIn = 1'b0;
  reg ccTestPassIn = 1'b0, regWr = 1'b0, regRd = 1'b0;
  reg [3:0] regAddr = 4'h0;
  reg [7:0] regWdata = 8'h00;
  wire [7:0] regRdata;
  wire [4:0] loopTestChan;
  wire loopTestActive, loopTestWhole, outOfServiceLamp, inServiceLamp, localAlarmLamp;
  wire farEndAlarmLamp, loopTestLamp, clockLampRed, clockLampGreen, handlerLampRed;
  wire handlerLampGreen;
  wire [4:0] card = {outOfServiceLamp, inServiceLamp, localAlarmLamp, farEndAlarmLamp,
                     loopTestLamp};
  wire [3:0] side = {clockLampRed, clockLampGreen, handlerLampRed, handlerLampGreen};
  int nFail = 0, checkCount = 0, i;
  logic [31:0] r;
  reg greenSeen;
  tcl_lamp_seq #(.HALF_CYC(H)) uut (.ref_clk(ref_clk), .srst(srst), .redAlarmIn(redAlarmIn),
    .yellowAlarmIn(yellowAlarmIn), .testPassIn(testPassIn), .testPartialIn(testPartialIn),
    .ccTestPassIn(ccTestPassIn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .loopTestActive(loopTestActive),
    .loopTestWhole(loopTestWhole), .loopTestChan(loopTestChan),
    .outOfServiceLamp(outOfServiceLamp), .inServiceLamp(inServiceLamp),
    .localAlarmLamp(localAlarmLamp), .farEndAlarmLamp(farEndAlarmLamp),
    .loopTestLamp(loopTestLamp), .clockLampRed(clockLampRed), .clockLampGreen(clockLampGreen),
    .handlerLampRed(handlerLampRed), .handlerLampGreen(handlerLampGreen));
  // ----------------------------------------
  // Bus tasks and model
  // ----------------------------------------
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task wr(input [3:0] a, input [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] ex);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    `CHK("regRdata", ex, regRdata)
  endtask
  function [3:0] exSide(input int k);
    exSide = (k < 4) ? 4'b0010 : (k < 8) ? {k % 2 == 0, 3'b010} : 4'b1010;
  endfunction
  // One sample per half second, taken mid-half to tolerate tick phase
  task powerRun(input bit part);
    logic [4:0] q[$];
    int k;
    q = {};
    for (k = 0; k < 24; k++) q.push_back(k < 22 ? 5'h1f : 5'h00);
    for (k = 0; k < (part ? 10 : 6); k++) q.push_back(k % 2 ? 5'h00 : 5'h1f);
    for (k = 0; k < 4; k++) q.push_back(5'h08);
    testPassIn <= !part;
    testPartialIn <= part;
    ccTestPassIn <= !part;
    redAlarmIn <= 1'b0;
    yellowAlarmIn <= 1'b0;
    srst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (H / 2) @(posedge ref_clk);
    for (k = 0; k < q.size(); k++) begin
      #1;
      `CHK("card lamps", q[k], card)
      if (!part || k < 4) `CHK("side lamps", exSide(k), side)
      else `CHK("handler lamps", 2'b10, side[1:0])
      repeat (H) @(posedge ref_clk);
    end
  endtask
  task printVerdict;
    $display("comparisons %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk);
    nFail++;
    printVerdict;
  end
  initial begin
    r = $urandom(61);
    powerRun(1'b0);
    $display("test power pass done");
    for (i = 0; i < 24; i++) begin
      r = $urandom;
      wr(4'h0, {3'b000, r[4:0]});
      redAlarmIn <= r[5];
      yellowAlarmIn <= r[6];
      repeat (6) @(posedge ref_clk);
      #1;
      `CHK("out of service", r[0], outOfServiceLamp)
      `CHK("in service", !r[0] && !r[5] && !r[6] && !r[1], inServiceLamp)
      `CHK("local alarm", r[5], localAlarmLamp)
      `CHK("far-end alarm", r[6], farEndAlarmLamp)
      `CHK("loop lamp", r[1], loopTestLamp)
      `CHK("clock red", !r[2], clockLampRed)
      if (!r[3] || !r[2]) `CHK("clock green", r[2], clockLampGreen)
      else begin
        greenSeen = clockLampGreen;
        repeat (H) @(posedge ref_clk);
        #1;
        `CHK("clock flash", !greenSeen, clockLampGreen)
      end
      `CHK("handler lamps", {!r[4], r[4]}, side[1:0])
      rd(4'h0, {3'b000, r[4:0]});
    end
    $display("test live lamps done");
    rd(4'h2, 8'h00);
    wr(4'h8, 8'h13);
    wr(4'hc, 8'h05);
    rd(4'h8, 8'h13);
    wr(4'h0, 8'h21);
    repeat (3) @(posedge ref_clk);
    `CHK("channel test", 7'h53, {loopTestActive, loopTestWhole, loopTestChan})
    wr(4'h0, 8'h80);
    repeat (3) @(posedge ref_clk);
    `CHK("test stopped", 1'b0, loopTestActive)
    wr(4'h0, 8'h10);
    wr(4'h0, 8'h70);
    repeat (3) @(posedge ref_clk);
    `CHK("whole test", 2'b11, {loopTestActive, loopTestWhole})
    rd(4'h4, 8'hd3);
    $display("test loop control done");
    powerRun(1'b1);
    $display("test power partial done");
    printVerdict;
  end
endmodule
